// file: pkg/rff_pkg.sv
`default_nettype none
package rff_pkg;
	localparam int NCH = 8;
	localparam logic [15:0] TAG_TYPE = 16'h8100;
	localparam logic [15:0] CTRL_TYPE = 16'h8808;
	localparam logic [2:0] HI_PRI_MIN = 3'h4;
	localparam int PRI_MSB = 15;
	localparam int PRI_LSB = 13;
	localparam logic [15:0] MIN_LEN = 16'h0040;
	localparam logic [15:0] FCS_KEEP_LEN = 16'h0014;
	localparam logic [15:0] FCS_BYTES = 16'h0004;
	localparam logic [15:0] MAX_LEN_RST = 16'h05EE;
	localparam logic [15:0] LEN_SAT = 16'hFFFF;
	localparam logic [15:0] IDX_TYPE_HI = 16'h000C;
	localparam logic [15:0] IDX_TYPE_LO = 16'h000D;
	localparam logic [15:0] IDX_TCI_HI = 16'h000E;
	localparam logic [15:0] IDX_TCI_LO = 16'h000F;
	localparam logic [31:0] TD_MARKER = 32'hFFFFFFFC;
	localparam logic [7:0] SFD_BYTE = 8'hD5;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
	localparam logic [31:0] CRC_POLY = 32'hEDB88320;
	localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;
	localparam logic [2:0] KIND_PROPER = 3'h0;
	localparam logic [2:0] KIND_OVERSIZE = 3'h1;
	localparam logic [2:0] KIND_JABBER = 3'h2;
	localparam logic [2:0] KIND_UNDERSIZE = 3'h3;
	localparam logic [2:0] KIND_FRAGMENT = 3'h4;
	localparam logic [2:0] KIND_ERROR = 3'h5;
	typedef enum logic [1:0] {LK_IDLE, LK_PRE, LK_DATA} rff_link_st_t;
endpackage : rff_pkg
`default_nettype wire

// file: hdl/rff_filter.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Type 8100h marks a tagged frame; next two bytes are the TCI.
// - Priority is TCI bits 15-13; 0-3 low, 4-7 high.
// - With QOS on, drop low priority when channel free count <= threshold.
// - Each consumed receive buffer decrements its channel free count.
// - A host write to a free count adds to it.
// - Free counts are sixteen bits per channel.
// - Teardown waits for frame end; flags descriptor if enabled with one available, clears head if enabled, always interrupts.
// - After teardown the completion pointer reads the teardown marker.
// - Teardown never changes any channel enable.
// - Teardown of an idle channel interrupts; marker write acknowledges.
// - Proper: 64 to max length bytes with no code, align, CRC error.
// - Longer than max is long: oversize if clean, jabber if errored.
// - Max frame length resets to 1518.
// - Under 64 bytes is short: undersized if clean, fragment if errored.
// - Frames of 20 bytes or fewer keep their CRC bytes.
// - Long frames store exactly max length bytes regardless of FCS setting.
// - Address match needs an enabled channel; else nonmatching.
// - Control frames match only with control accept; error bits never match.
// - Nonmatching frames stored only with accept-all, per type bits.
// - Matching frames go to match channel; type bits add error kinds.
// - Promiscuous select names the channel for promiscuous admissions.
module rff_filter (
	input wire logic clock,
	input wire logic nrst,
	input wire logic rx_clk,
	input wire logic [3:0] mii_rxd,
	input wire logic mii_rx_dv,
	input wire logic mii_rx_er,
	input wire logic qos_enable_bit,
	input wire logic accept_error_frames,
	input wire logic accept_all_frames,
	input wire logic accept_control_frames,
	input wire logic accept_short_frames,
	input wire logic pass_fcs_bit,
	input wire logic [2:0] promiscuous_channel_select,
	input wire logic [15:0] low_priority_filter_threshold,
	input wire logic max_len_wr,
	input wire logic [15:0] max_len_data,
	input wire logic addr_hit,
	input wire logic [2:0] addr_hit_chan,
	input wire logic addr_chan_enabled,
	input wire logic fb_wr_en,
	input wire logic [2:0] fb_wr_chan,
	input wire logic [15:0] fb_wr_data,
	input wire logic buf_used,
	input wire logic [2:0] buf_used_chan,
	input wire logic [2:0] fb_rd_chan,
	input wire logic rx_teardown_command,
	input wire logic [2:0] td_chan,
	input wire logic [7:0] chan_enable,
	input wire logic [7:0] desc_avail,
	input wire logic cp_ack_wr,
	input wire logic [2:0] cp_ack_chan,
	input wire logic [31:0] cp_ack_data,
	input wire logic [2:0] cp_rd_chan,
	input wire logic [31:0] cp_dma_value,
	output logic frame_accept,
	output logic frame_drop,
	output logic qos_drop,
	output logic [2:0] frame_channel,
	output logic frame_addr_match,
	output logic [2:0] frame_kind,
	output logic frame_hi_pri,
	output logic [15:0] frame_length,
	output logic [15:0] store_length,
	output logic [15:0] max_frame_length,
	output logic td_done,
	output logic [2:0] td_done_chan,
	output logic teardown_complete_flag,
	output logic head_ptr_clear,
	output logic [7:0] rx_irq,
	output logic [31:0] rx_completion_pointer,
	output logic [15:0] channel_free_buffer_count
);
	// ----------------------------------------------------------------
	// Link side state
	// ----------------------------------------------------------------
	typedef struct packed {
		rff_pkg::rff_link_st_t st;
		logic hi;
		logic [3:0] lo;
		logic [15:0] cnt;
		logic [15:0] etype;
		logic [15:0] tci;
		logic [31:0] crc;
		logic code_err;
		logic active;
		logic tgl;
		logic [15:0] s_len;
		logic s_tag;
		logic [2:0] s_pri;
		logic s_ctrl;
		logic s_crc;
		logic s_code;
		logic s_align;
	} rff_link_t;

	// ----------------------------------------------------------------
	// Core side state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0] tsync;
		logic [1:0] bsync;
		logic [15:0] max_len;
		logic [7:0][15:0] fb;
		logic [7:0] td_pend;
		logic [7:0] td_mark;
		logic acc;
		logic drop;
		logic qdrop;
		logic [2:0] chan;
		logic am;
		logic [2:0] kind;
		logic hi_pri;
		logic [15:0] flen;
		logic [15:0] slen;
		logic tdd;
		logic [2:0] tdc;
		logic tdflag;
		logic hclr;
		logic [7:0] irq;
		logic [31:0] cp_rd;
		logic [15:0] fb_rd;
	} rff_core_t;

	rff_link_t lk_reg, lk_next;
	rff_core_t cr_reg, cr_next;

	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] x;
		x = c;
		for (int k = 0; k < 8; k++) begin
			x = (x[0] ^ b[k]) ? ((x >> 1) ^ rff_pkg::CRC_POLY) : (x >> 1);
		end
		return x;
	endfunction : crc_byte

	// ----------------------------------------------------------------
	// MII receive, link clock
	// ----------------------------------------------------------------
	always_comb begin
		logic [7:0] b;
		logic bad;
		b = {mii_rxd, lk_reg.lo};
		bad = (lk_reg.crc != rff_pkg::CRC_RESIDUE);
		lk_next = lk_reg;
		unique case (lk_reg.st)
			rff_pkg::LK_IDLE: begin
				lk_next.hi = 1'b0;
				if (mii_rx_dv) begin
					lk_next.lo = mii_rxd;
					lk_next.hi = 1'b1;
					lk_next.active = 1'b1;
					lk_next.st = rff_pkg::LK_PRE;
				end
			end
			rff_pkg::LK_PRE: begin
				if (!mii_rx_dv) begin
					lk_next.active = 1'b0;
					lk_next.st = rff_pkg::LK_IDLE;
				end else if (!lk_reg.hi) begin
					lk_next.lo = mii_rxd;
					lk_next.hi = 1'b1;
				end else if (b == rff_pkg::SFD_BYTE) begin
					lk_next.hi = 1'b0;
					lk_next.cnt = '0;
					lk_next.etype = '0;
					lk_next.tci = '0;
					lk_next.crc = rff_pkg::CRC_INIT;
					lk_next.code_err = 1'b0;
					lk_next.st = rff_pkg::LK_DATA;
				end else begin
					lk_next.lo = mii_rxd;
				end
			end
			rff_pkg::LK_DATA: begin
				if (mii_rx_dv) begin
					if (mii_rx_er) begin
						lk_next.code_err = 1'b1;
					end
					lk_next.hi = !lk_reg.hi;
					if (!lk_reg.hi) begin
						lk_next.lo = mii_rxd;
					end else begin
						lk_next.crc = crc_byte(lk_reg.crc, b);
						if (lk_reg.cnt != rff_pkg::LEN_SAT) begin
							lk_next.cnt = lk_reg.cnt + 16'h0001;
						end
						if (lk_reg.cnt == rff_pkg::IDX_TYPE_HI) lk_next.etype[15:8] = b;
						if (lk_reg.cnt == rff_pkg::IDX_TYPE_LO) lk_next.etype[7:0] = b;
						if (lk_reg.cnt == rff_pkg::IDX_TCI_HI) lk_next.tci[15:8] = b;
						if (lk_reg.cnt == rff_pkg::IDX_TCI_LO) lk_next.tci[7:0] = b;
					end
				end else begin
					// Summary stays put until the next frame ends, so the core may read it
					lk_next.s_len = lk_reg.cnt;
					lk_next.s_tag = (lk_reg.etype == rff_pkg::TAG_TYPE);
					lk_next.s_pri = lk_reg.tci[rff_pkg::PRI_MSB:rff_pkg::PRI_LSB];
					lk_next.s_ctrl = (lk_reg.etype == rff_pkg::CTRL_TYPE);
					lk_next.s_crc = bad;
					lk_next.s_code = lk_reg.code_err;
					lk_next.s_align = bad && lk_reg.hi;
					lk_next.tgl = !lk_reg.tgl;
					lk_next.active = 1'b0;
					lk_next.st = rff_pkg::LK_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge rx_clk or negedge nrst) begin
		if (!nrst) begin
			lk_reg <= '0;
		end else begin
			lk_reg <= lk_next;
		end
	end

	// ----------------------------------------------------------------
	// Qualification, free counts and teardown, core clock
	// ----------------------------------------------------------------
	always_comb begin
		logic edge_s, err, is_long, is_short, proper, am, base, keep, low_pri, found;
		logic [2:0] ch, sel;
		logic [15:0] len;
		logic [7:0] clr, setm;
		cr_next = cr_reg;
		cr_next.tsync = {cr_reg.tsync[1:0], lk_reg.tgl};
		cr_next.bsync = {cr_reg.bsync[0], lk_reg.active};
		edge_s = cr_reg.tsync[2] ^ cr_reg.tsync[1];
		if (max_len_wr) begin
			cr_next.max_len = max_len_data;
		end
		for (int i = 0; i < rff_pkg::NCH; i++) begin
			if (fb_wr_en && fb_wr_chan == 3'(i)) begin
				cr_next.fb[i] = cr_next.fb[i] + fb_wr_data;
			end
			if (buf_used && buf_used_chan == 3'(i)) begin
				cr_next.fb[i] = cr_next.fb[i] - 16'h0001;
			end
		end
		len = lk_reg.s_len;
		err = lk_reg.s_crc || lk_reg.s_code || lk_reg.s_align;
		is_long = len > cr_reg.max_len;
		is_short = len < rff_pkg::MIN_LEN;
		proper = !is_long && !is_short && !err;
		am = addr_hit && addr_chan_enabled;
		am = am && (!lk_reg.s_ctrl || accept_control_frames);
		base = is_short ? (accept_short_frames && (!err || accept_error_frames))
			: (proper || accept_error_frames);
		base = base && (!lk_reg.s_ctrl || accept_control_frames);
		keep = base && (am || accept_all_frames);
		ch = am ? addr_hit_chan : promiscuous_channel_select;
		low_pri = !lk_reg.s_tag || (lk_reg.s_pri < rff_pkg::HI_PRI_MIN);
		cr_next.acc = 1'b0;
		cr_next.drop = 1'b0;
		cr_next.qdrop = 1'b0;
		if (edge_s) begin
			cr_next.qdrop = keep && qos_enable_bit && low_pri
				&& (cr_reg.fb[ch] <= low_priority_filter_threshold);
			cr_next.acc = keep && !cr_next.qdrop;
			cr_next.drop = !cr_next.acc;
			cr_next.chan = ch;
			cr_next.am = am;
			cr_next.hi_pri = !low_pri;
			cr_next.flen = len;
			if (is_long) begin
				cr_next.kind = err ? rff_pkg::KIND_JABBER : rff_pkg::KIND_OVERSIZE;
				cr_next.slen = cr_reg.max_len;
			end else begin
				if (is_short) begin
					cr_next.kind = err ? rff_pkg::KIND_FRAGMENT : rff_pkg::KIND_UNDERSIZE;
				end else begin
					cr_next.kind = err ? rff_pkg::KIND_ERROR : rff_pkg::KIND_PROPER;
				end
				if (pass_fcs_bit || len <= rff_pkg::FCS_KEEP_LEN) begin
					cr_next.slen = len;
				end else begin
					cr_next.slen = len - rff_pkg::FCS_BYTES;
				end
			end
		end
		// One teardown per cycle, lowest channel first, never inside a frame
		found = 1'b0;
		sel = 3'h0;
		for (int i = rff_pkg::NCH - 1; i >= 0; i--) begin
			if (cr_reg.td_pend[i]) begin
				found = 1'b1;
				sel = 3'(i);
			end
		end
		clr = '0;
		setm = '0;
		cr_next.tdd = 1'b0;
		cr_next.tdflag = 1'b0;
		cr_next.hclr = 1'b0;
		cr_next.irq = '0;
		if (found && !cr_reg.bsync[1]) begin
			clr[sel] = 1'b1;
			setm[sel] = 1'b1;
			cr_next.tdd = 1'b1;
			cr_next.tdc = sel;
			cr_next.tdflag = chan_enable[sel] && desc_avail[sel];
			cr_next.hclr = chan_enable[sel];
			cr_next.irq[sel] = 1'b1;
		end
		cr_next.td_pend = cr_reg.td_pend & ~clr;
		if (rx_teardown_command) begin
			cr_next.td_pend[td_chan] = 1'b1;
		end
		if (cp_ack_wr && cp_ack_data == rff_pkg::TD_MARKER) begin
			cr_next.td_mark[cp_ack_chan] = 1'b0;
		end
		cr_next.td_mark = cr_next.td_mark | setm;
		cr_next.cp_rd = cr_reg.td_mark[cp_rd_chan] ? rff_pkg::TD_MARKER : cp_dma_value;
		cr_next.fb_rd = cr_reg.fb[fb_rd_chan];
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cr_reg <= '0;
			cr_reg.max_len <= rff_pkg::MAX_LEN_RST;
		end else begin
			cr_reg <= cr_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Channel enables are inputs only; teardown has no path to them
	assign frame_accept = cr_reg.acc;
	assign frame_drop = cr_reg.drop;
	assign qos_drop = cr_reg.qdrop;
	assign frame_channel = cr_reg.chan;
	assign frame_addr_match = cr_reg.am;
	assign frame_kind = cr_reg.kind;
	assign frame_hi_pri = cr_reg.hi_pri;
	assign frame_length = cr_reg.flen;
	assign store_length = cr_reg.slen;
	assign max_frame_length = cr_reg.max_len;
	assign td_done = cr_reg.tdd;
	assign td_done_chan = cr_reg.tdc;
	assign teardown_complete_flag = cr_reg.tdflag;
	assign head_ptr_clear = cr_reg.hclr;
	assign rx_irq = cr_reg.irq;
	assign rx_completion_pointer = cr_reg.cp_rd;
	assign channel_free_buffer_count = cr_reg.fb_rd;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_TAG_SEEN: assert property (@(posedge rx_clk) disable iff (!nrst)
		$fell(lk_reg.active) && $past(lk_reg.etype) == rff_pkg::TAG_TYPE |-> lk_reg.s_tag)
		else $error("tag type not recognised");
	AST_QOS_NOT_ACC: assert property (@(posedge clock) disable iff (!nrst)
		qos_drop |-> frame_drop && !frame_accept && !frame_hi_pri)
		else $error("qos drop inconsistent");
	AST_FB_DEC: assert property (@(posedge clock) disable iff (!nrst)
		buf_used && !fb_wr_en |=> cr_reg.fb[$past(buf_used_chan)]
			== $past(cr_reg.fb[buf_used_chan]) - 16'h0001)
		else $error("free count not decremented");
	AST_FB_ADD: assert property (@(posedge clock) disable iff (!nrst)
		fb_wr_en && !buf_used |=> cr_reg.fb[$past(fb_wr_chan)]
			== $past(cr_reg.fb[fb_wr_chan]) + $past(fb_wr_data))
		else $error("free count not added");
	AST_TD_IDLE: assert property (@(posedge clock) disable iff (!nrst)
		td_done |-> $past(!cr_reg.bsync[1]) && rx_irq[td_done_chan])
		else $error("teardown during frame or no interrupt");
	AST_TD_MARK: assert property (@(posedge clock) disable iff (!nrst)
		td_done && cp_rd_chan == td_done_chan |=> rx_completion_pointer == rff_pkg::TD_MARKER)
		else $error("marker not returned");
	AST_MAX_RST: assert property (@(posedge clock) disable iff (!nrst)
		$rose(nrst) |-> max_frame_length == rff_pkg::MAX_LEN_RST)
		else $error("max length reset value wrong");
	AST_SHORT_FCS: assert property (@(posedge clock) disable iff (!nrst)
		frame_accept && frame_length <= rff_pkg::FCS_KEEP_LEN |-> store_length == frame_length)
		else $error("short frame lost fcs");
	AST_LONG_TRUNC: assert property (@(posedge clock) disable iff (!nrst)
		frame_accept && frame_length > max_frame_length |-> store_length == max_frame_length)
		else $error("long frame not truncated");
	AST_PROM_CHAN: assert property (@(posedge clock) disable iff (!nrst)
		frame_accept && !frame_addr_match |-> $past(accept_all_frames)
			&& frame_channel == $past(promiscuous_channel_select))
		else $error("promiscuous routing wrong");
endmodule : rff_filter
`default_nettype wire

// file: testbench/rff_phy_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// PHY side of the MII receive link
// ----------------------------------------
module rff_phy_model (
	input wire logic nrst,
	output logic rx_clk,
	output logic [3:0] mii_rxd,
	output logic mii_rx_dv,
	output logic mii_rx_er
);
	logic run = 1'b0;
	logic code_err_req = 1'b0;
	logic [7:0] fr [0:255];
	// Clock stands still between frames, so the core cannot lean on it
	initial begin
		rx_clk = 1'b0;
		mii_rxd = 4'hA;
		mii_rx_dv = 1'b0;
		mii_rx_er = 1'b0;
		#1.5;
		forever begin
			#6;
			if (run || !nrst || rx_clk) rx_clk = ~rx_clk;
		end
	end
	task automatic nib(input logic [3:0] n);
		@(negedge rx_clk);
		mii_rx_dv = 1'b1;
		mii_rxd = n;
		mii_rx_er = code_err_req;
	endtask : nib
	task automatic send_frame(input int len, input logic [15:0] ty, input logic [15:0] tci,
		input bit bad);
		logic [31:0] crc;
		crc = rff_pkg::CRC_INIT;
		for (int i = 0; i < len; i++) fr[i] = i[7:0];
		{fr[12], fr[13], fr[14], fr[15]} = {ty, tci};
		for (int i = 0; i < len - 4; i++) begin
			crc = crc ^ {24'h0, fr[i]};
			repeat (8) crc = crc[0] ? (crc >> 1) ^ rff_pkg::CRC_POLY : crc >> 1;
		end
		crc = ~crc ^ {31'h0, bad};
		for (int k = 0; k < 4; k++) fr[len - 4 + k] = crc[8 * k +: 8];
		run = 1'b1;
		repeat (15) nib(4'h5);
		nib(4'hD);
		for (int i = 0; i < len; i++) begin
			nib(fr[i][3:0]);
			nib(fr[i][7:4]);
		end
		@(negedge rx_clk);
		mii_rx_dv = 1'b0;
		mii_rx_er = 1'b0;
		// Released data lines toggle so a stale nibble never reads as valid
		repeat (9) @(negedge rx_clk) mii_rxd = ~mii_rxd;
		run = 1'b0;
	endtask : send_frame
endmodule : rff_phy_model
`default_nettype wire

// file: testbench/rff_filter_tb.sv
`timescale 1ns/100ps
`default_nettype none
module rff_filter_tb;
	logic clock = 1'b0;
	logic nrst, rx_clk, mii_rx_dv, mii_rx_er, qos_enable_bit, accept_error_frames;
	logic accept_all_frames, accept_control_frames, accept_short_frames, pass_fcs_bit;
	logic max_len_wr, addr_hit, addr_chan_enabled, fb_wr_en, buf_used, rx_teardown_command;
	logic cp_ack_wr, frame_accept, frame_drop, qos_drop, frame_addr_match, frame_hi_pri;
	logic td_done, teardown_complete_flag, head_ptr_clear, got_acc, got_qos, got_drop;
	logic [2:0] promiscuous_channel_select, addr_hit_chan, fb_wr_chan, buf_used_chan, fb_rd_chan;
	logic [2:0] td_chan, cp_ack_chan, cp_rd_chan, frame_channel, frame_kind, td_done_chan;
	logic [3:0] mii_rxd;
	logic [7:0] chan_enable, desc_avail, rx_irq;
	logic [15:0] low_priority_filter_threshold, max_len_data, fb_wr_data, frame_length;
	logic [15:0] store_length, max_frame_length, channel_free_buffer_count;
	logic [31:0] cp_ack_data, cp_dma_value, rx_completion_pointer;
	int err_total = 0;
	int total_checks = 0;
	int dec_cnt = 0;
	int td_cnt = 0;
	rff_phy_model u_rff_phy_model (.nrst, .rx_clk, .mii_rxd, .mii_rx_dv, .mii_rx_er);
	rff_filter u_rff_filter (.clock, .nrst, .rx_clk, .mii_rxd, .mii_rx_dv, .mii_rx_er,
		.qos_enable_bit, .accept_error_frames, .accept_all_frames, .accept_control_frames,
		.accept_short_frames, .pass_fcs_bit, .promiscuous_channel_select,
		.low_priority_filter_threshold, .max_len_wr, .max_len_data, .addr_hit, .addr_hit_chan,
		.addr_chan_enabled, .fb_wr_en, .fb_wr_chan, .fb_wr_data, .buf_used, .buf_used_chan,
		.fb_rd_chan, .rx_teardown_command, .td_chan, .chan_enable, .desc_avail, .cp_ack_wr,
		.cp_ack_chan, .cp_ack_data, .cp_rd_chan, .cp_dma_value, .frame_accept, .frame_drop,
		.qos_drop, .frame_channel, .frame_addr_match, .frame_kind, .frame_hi_pri, .frame_length,
		.store_length, .max_frame_length, .td_done, .td_done_chan, .teardown_complete_flag,
		.head_ptr_clear, .rx_irq, .rx_completion_pointer, .channel_free_buffer_count);
	always #2 clock = ~clock;
	// Decision pulses last one cycle, so they are caught here
	always @(negedge clock) begin
		if (frame_accept === 1'b1 || frame_drop === 1'b1) begin
			dec_cnt <= dec_cnt + 1;
			got_acc <= frame_accept;
			got_drop <= frame_drop;
			got_qos <= qos_drop;
		end
		if (td_done === 1'b1) td_cnt <= td_cnt + 1;
	end
	task automatic final_report;
		if (err_total == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge clock);
	endtask : tick
	task automatic send(input int len, input logic [15:0] ty, input logic [15:0] tci, input bit bad);
		int n0;
		n0 = dec_cnt;
		u_rff_phy_model.send_frame(len, ty, tci, bad);
		for (int i = 0; i < 40 && dec_cnt == n0; i++) @(negedge clock);
		if (dec_cnt == n0) begin
			err_total++;
			final_report();
		end
		@(negedge clock);
	endtask : send
	task automatic fb(input logic wr, input logic [2:0] ch, input logic [15:0] d, input logic u);
		fb_wr_en = wr;
		fb_wr_chan = ch;
		fb_wr_data = d;
		buf_used = u;
		buf_used_chan = ch;
		fb_rd_chan = ch;
		@(negedge clock);
		fb_wr_en = 1'b0;
		buf_used = 1'b0;
		tick(2);
	endtask : fb
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_count;
		fb(1'b1, 3'h2, 16'h0005, 1'b0);
		chk(channel_free_buffer_count, 16'h0005);
		fb(1'b1, 3'h2, 16'h0003, 1'b0);
		chk(channel_free_buffer_count, 16'h0008);
		fb(1'b0, 3'h2, 16'h0000, 1'b1);
		chk(channel_free_buffer_count, 16'h0007);
		fb(1'b1, 3'h2, 16'h0004, 1'b1);
		chk(channel_free_buffer_count, 16'h000A);
		fb(1'b1, 3'h1, 16'hFFFF, 1'b0);
		chk(channel_free_buffer_count, 16'hFFFF);
		fb(1'b1, 3'h1, 16'h0002, 1'b0);
		chk(channel_free_buffer_count, 16'h0001);
		fb(1'b0, 3'h2, 16'h0000, 1'b0);
		chk(channel_free_buffer_count, 16'h000A);
	endtask : t_count
	task automatic t_qos;
		addr_hit = 1'b1;
		addr_chan_enabled = 1'b1;
		qos_enable_bit = 1'b1;
		low_priority_filter_threshold = 16'h0002;
		fb(1'b1, 3'h0, 16'h0002, 1'b0);
		for (int p = 0; p < 8; p++) begin
			send(64, rff_pkg::TAG_TYPE, {p[2:0], 13'h0}, 1'b0);
			chk(got_acc, p > 3);
			chk(got_qos, p < 4);
			chk(got_drop, p < 4);
			chk(frame_hi_pri, p > 3);
		end
		send(64, 16'h0800, 16'hE000, 1'b0);
		chk(got_acc, 1'b0);
		chk(frame_hi_pri, 1'b0);
		// One more free buffer lifts the count above the threshold
		fb(1'b1, 3'h0, 16'h0001, 1'b0);
		send(64, 16'h0800, 16'h0000, 1'b0);
		chk(got_acc, 1'b1);
		qos_enable_bit = 1'b0;
	endtask : t_qos
	task automatic t_class;
		int tab [11][5] = '{'{20, 0, 0, 3, 20}, '{21, 0, 0, 3, 17}, '{63, 0, 0, 3, 59},
			'{64, 0, 0, 0, 60}, '{64, 0, 1, 0, 64}, '{100, 0, 0, 0, 96}, '{101, 0, 0, 1, 100},
			'{101, 0, 1, 1, 100}, '{102, 1, 0, 2, 100}, '{63, 1, 0, 4, 59}, '{80, 1, 0, 5, 76}};
		accept_error_frames = 1'b1;
		accept_short_frames = 1'b1;
		max_len_wr = 1'b1;
		max_len_data = 16'h0064;
		@(negedge clock);
		max_len_wr = 1'b0;
		@(negedge clock);
		chk(max_frame_length, 16'h0064);
		foreach (tab[i]) begin
			pass_fcs_bit = tab[i][2][0];
			send(tab[i][0], 16'h0800, 16'h0000, tab[i][1][0]);
			chk(got_acc, 1'b1);
			chk(frame_length, tab[i][0]);
			chk(frame_kind, tab[i][3]);
			chk(store_length, tab[i][4]);
		end
		// Code error on the link with a good CRC
		u_rff_phy_model.code_err_req = 1'b1;
		send(80, 16'h0800, 16'h0000, 1'b0);
		u_rff_phy_model.code_err_req = 1'b0;
		chk(got_acc, 1'b1);
		chk(frame_kind, rff_pkg::KIND_ERROR);
		pass_fcs_bit = 1'b0;
	endtask : t_class
	task automatic t_filter;
		logic am, keep;
		int lens [4] = '{64, 40, 80, 64};
		addr_hit_chan = 3'h5;
		promiscuous_channel_select = 3'h6;
		for (int c = 0; c < 32; c++) begin
			{accept_short_frames, accept_control_frames, accept_error_frames, accept_all_frames,
				addr_chan_enabled} = c[4:0];
			for (int f = 0; f < 4; f++) begin
				am = c[0] && (f != 3 || c[3]);
				keep = (am || c[1]) && (f == 0 || (f == 1 && c[4]) || (f == 2 && c[2])
					|| (f == 3 && c[3]));
				send(lens[f], (f == 3) ? rff_pkg::CTRL_TYPE : 16'h0800, 16'h0000, f == 2);
				chk(frame_addr_match, am);
				chk(got_acc, keep);
				if (keep) chk(frame_channel, am ? 3'h5 : 3'h6);
			end
		end
	endtask : t_filter
	task automatic td(input logic [2:0] ch, input logic fl);
		rx_teardown_command = 1'b1;
		td_chan = ch;
		cp_rd_chan = ch;
		@(negedge clock);
		rx_teardown_command = 1'b0;
		@(negedge clock);
		chk(td_done, 1'b1);
		chk(td_done_chan, ch);
		chk(rx_irq, 8'h01 << ch);
		chk(teardown_complete_flag, fl);
		chk(head_ptr_clear, fl);
		@(negedge clock);
		chk(rx_completion_pointer, rff_pkg::TD_MARKER);
		cp_ack_wr = 1'b1;
		cp_ack_chan = ch;
		cp_ack_data = 32'h00000001;
		@(negedge clock);
		cp_ack_wr = 1'b0;
		tick(2);
		chk(rx_completion_pointer, rff_pkg::TD_MARKER);
		cp_ack_wr = 1'b1;
		cp_ack_data = rff_pkg::TD_MARKER;
		@(negedge clock);
		cp_ack_wr = 1'b0;
		tick(2);
		chk(rx_completion_pointer, cp_dma_value);
	endtask : td
	task automatic t_td;
		int n;
		chan_enable = 8'h08;
		desc_avail = 8'h08;
		cp_dma_value = 32'h00001230;
		td(3'h3, 1'b1);
		td(3'h5, 1'b0);
		n = td_cnt;
		fork
			send(200, 16'h0800, 16'h0000, 1'b0);
			begin
				tick(150);
				rx_teardown_command = 1'b1;
				td_chan = 3'h1;
				@(negedge clock);
				rx_teardown_command = 1'b0;
				tick(20);
				chk(td_cnt, n);
			end
		join
		tick(20);
		chk(td_cnt, n + 1);
	endtask : t_td
	initial begin
		nrst = 1'b0;
		{qos_enable_bit, accept_error_frames, accept_all_frames, accept_control_frames,
			accept_short_frames, pass_fcs_bit, promiscuous_channel_select,
			low_priority_filter_threshold, max_len_wr, max_len_data, addr_hit, addr_hit_chan,
			addr_chan_enabled, fb_wr_en, fb_wr_chan, fb_wr_data, buf_used, buf_used_chan,
			fb_rd_chan, rx_teardown_command, td_chan, chan_enable, desc_avail, cp_ack_wr,
			cp_ack_chan, cp_ack_data, cp_rd_chan, cp_dma_value} = '0;
		tick(10);
		nrst = 1'b1;
		@(negedge clock);
		chk(max_frame_length, rff_pkg::MAX_LEN_RST);
		t_count();
		t_qos();
		t_class();
		t_filter();
		t_td();
		final_report();
	end
endmodule : rff_filter_tb
`default_nettype wire
